// >>> verilog/eepslv_pkg.sv
// Shared constants and types for the two-wire memory slave
package eepslv_pkg;

   // Array organisation
   localparam int MEM_DEPTH = 256;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_IDX_W = 4;

   // Fixed upper nibble of the device-select byte; arbitrary value
   localparam logic [3:0] DEV_ID = 4'h6;

   // Self-timed programming cycle, longest time 5 ms at 40 MHz
   localparam int CLK_HZ = 40000000;
   localparam int PROG_T_MS = 5;
   localparam int PROG_CYC = (CLK_HZ / 1000) * PROG_T_MS;
   localparam int BUSY_W = 20;

   // Bit counts of a byte on the link
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_FULL = 4'h8;

   // Wishbone register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;

   // Field positions
   localparam int CTRL_WP_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STBY_BIT = 1;
   localparam int STAT_WP_BIT = 2;
   localparam int STAT_PTR_LSB = 8;

   // Link protocol states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEVSEL,
      ST_ACK_DEV,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_WDATA,
      ST_ACK_WDATA,
      ST_RDATA,
      ST_RACK,
      ST_IGNORE
   } eepslv_state_t;

endpackage : eepslv_pkg

// >>> verilog/eepslv_top.sv
// Function
// R1: Array holds 256 bytes, programmed in pages of 16 consecutive bytes.
// R2: Partial page transfers program only the bytes actually received.
// R3: Programming runs self-timed and completes within 5 ms.
// R4: Master keeps serial clock at or below 400 kHz or 1 MHz.
// R5: During power-on reset all bus traffic is ignored.
// R6: Reset release clears the state machine into standby, no programming.
// R7: Stop returns to standby, or after a running programming cycle ends.
// R8: Data line is only pulled low, otherwise released.
// R9: Three straps set address bits; respond only to own address.
// R10: Unconnected strap inputs count as logic zero.
// R11: Write protect high blocks all array programming, read-only.
// R12: Write protect low or open allows normal programming.
// R13: Transfer carries device-select, then location address, then data.
// R14: Data sampled and shifted only with master serial clock edges.
// R15: Device-select LSB one means read, zero means write.
// R16: Page writes advance only low four pointer bits, wrapping in page.
// R17: No acknowledge or response while programming is in progress.
// R18: Master polls with write device-select until acknowledged.
// R19: Under protection, write bytes are acknowledged but nothing is programmed.
// R20: Eight-bit location pointer loaded by write transfer address byte.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module eepslv_top
   import eepslv_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC // Programming cycle length in clocks
)
(
   input wire logic core_clk, // System clock, 40 MHz
   input wire logic rst, // Synchronous reset, acts as power-on reset
   input wire logic scl_in, // Serial clock pin from master
   input wire logic sda_in, // Serial data pin level
   output logic sda_out, // Serial data drive value, always low
   output logic sda_oe, // Serial data pull-low enable
   input wire logic strap_addr_bit0, // Address strap bit 0
   input wire logic strap_addr_bit1, // Address strap bit 1
   input wire logic strap_addr_bit2, // Address strap bit 2
   input wire logic wp_in, // Write protect pin
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o // Wishbone acknowledge
);

   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic [1:0] wp_sy;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      eepslv_state_t st;
      logic [7:0] shreg;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic [3:0] page;
      logic [PAGE_BYTES-1:0] mask;
      logic more;
      logic [BUSY_W-1:0] busy;
      logic soft_wp;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic sda_drv;
   } eepslv_regs_t;

   eepslv_regs_t r_ff;
   eepslv_regs_t nxt_r;

   logic [7:0] mem [0:MEM_DEPTH-1]; // [R1]
   logic [7:0] pbuf [0:PAGE_BYTES-1];
   logic buf_we;
   logic [PAGE_IDX_W-1:0] buf_idx;
   logic prog_done;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic wp_eff;
   logic addr_hit;
   logic [7:0] rd_byte;
   logic wb_req;

   // Edges from the second and third synchroniser stages only
   assign scl_rise = r_ff.scl_sy[1] & ~r_ff.scl_sy[2]; // [R14]
   assign scl_fall = ~r_ff.scl_sy[1] & r_ff.scl_sy[2]; // [R14]
   assign start_det = r_ff.scl_sy[1] & r_ff.scl_sy[2] & ~r_ff.sda_sy[1] & r_ff.sda_sy[2];
   assign stop_det = r_ff.scl_sy[1] & r_ff.scl_sy[2] & r_ff.sda_sy[1] & ~r_ff.sda_sy[2];
   assign wp_eff = r_ff.wp_sy[1] | r_ff.soft_wp; // [R11] [R12]
   assign addr_hit = (r_ff.shreg[7:4] == DEV_ID) && (r_ff.shreg[3:1] == r_ff.strap_s2); // [R9]
   assign prog_done = (r_ff.busy == BUSY_W'(1));
   assign rd_byte = mem[r_ff.ptr];
   assign wb_req = wb_cyc_i & wb_stb_i & ~r_ff.wb_ack;

   // Next-state logic for link, programming timer and register bus
   always_comb
   begin
      nxt_r = r_ff;
      buf_we = 1'b0;
      buf_idx = r_ff.ptr[PAGE_IDX_W-1:0];
      nxt_r.scl_sy = {r_ff.scl_sy[1:0], scl_in};
      nxt_r.sda_sy = {r_ff.sda_sy[1:0], sda_in};
      nxt_r.wp_sy = {r_ff.wp_sy[0], wp_in};
      nxt_r.strap_s1 = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}; // [R10]
      nxt_r.strap_s2 = r_ff.strap_s1;
      // Self-timed programming countdown
      if (r_ff.busy != '0)
      begin
         nxt_r.busy = r_ff.busy - BUSY_W'(1); // [R3]
      end
      if (prog_done)
      begin
         nxt_r.mask = '0;
      end
      // Link protocol; start and stop take priority over bit traffic
      if (start_det)
      begin
         nxt_r.st = ST_DEVSEL; // [R13]
         nxt_r.cnt = '0;
      end
      else if (stop_det)
      begin
         nxt_r.st = ST_IDLE; // [R7]
         if (r_ff.mask != '0 && r_ff.busy == '0)
         begin
            if (wp_eff)
            begin
               nxt_r.mask = '0; // [R11] [R19]
            end
            else
            begin
               nxt_r.busy = BUSY_W'(PROG_CYCLES); // [R3] [R12]
            end
         end
      end
      else
      begin
         case (r_ff.st)
            ST_DEVSEL, ST_ADDR, ST_WDATA:
            begin
               if (scl_rise && r_ff.cnt != BIT_FULL)
               begin
                  nxt_r.shreg = {r_ff.shreg[6:0], r_ff.sda_sy[1]}; // [R14]
                  nxt_r.cnt = r_ff.cnt + 4'h1;
               end
               else if (scl_fall && r_ff.cnt == BIT_FULL)
               begin
                  nxt_r.cnt = '0;
                  if (r_ff.st == ST_DEVSEL)
                  begin
                     // Silent while busy or addressed elsewhere
                     nxt_r.st = (addr_hit && r_ff.busy == '0) ? ST_ACK_DEV : ST_IGNORE; // [R17]
                  end
                  else if (r_ff.st == ST_ADDR)
                  begin
                     nxt_r.st = ST_ACK_ADDR;
                     nxt_r.ptr = r_ff.shreg; // [R20]
                     nxt_r.page = r_ff.shreg[7:4];
                     nxt_r.mask = '0;
                  end
                  else
                  begin
                     nxt_r.st = ST_ACK_WDATA;
                     buf_we = 1'b1; // [R2]
                     nxt_r.mask[r_ff.ptr[PAGE_IDX_W-1:0]] = 1'b1; // [R2]
                     nxt_r.ptr = {r_ff.ptr[7:4], r_ff.ptr[3:0] + 4'h1}; // [R16]
                  end
               end
            end
            ST_ACK_DEV:
            begin
               if (scl_fall)
               begin
                  if (r_ff.shreg[0])
                  begin
                     nxt_r.st = ST_RDATA; // [R15]
                     nxt_r.shreg = rd_byte;
                     nxt_r.ptr = r_ff.ptr + 8'h01;
                  end
                  else
                  begin
                     nxt_r.st = ST_ADDR; // [R15]
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_WDATA:
            begin
               if (scl_fall)
               begin
                  nxt_r.st = ST_WDATA; // [R13]
               end
            end
            ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (r_ff.cnt == BIT_LAST)
                  begin
                     nxt_r.st = ST_RACK;
                  end
                  else
                  begin
                     nxt_r.shreg = {r_ff.shreg[6:0], 1'b1};
                     nxt_r.cnt = r_ff.cnt + 4'h1;
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
               begin
                  nxt_r.more = ~r_ff.sda_sy[1];
               end
               else if (scl_fall)
               begin
                  nxt_r.cnt = '0;
                  if (r_ff.more)
                  begin
                     nxt_r.st = ST_RDATA;
                     nxt_r.shreg = rd_byte;
                     nxt_r.ptr = r_ff.ptr + 8'h01;
                  end
                  else
                  begin
                     nxt_r.st = ST_IGNORE;
                  end
               end
            end
            ST_IDLE, ST_IGNORE:
            begin
               nxt_r.st = r_ff.st;
            end
            default:
            begin
               nxt_r.st = ST_IDLE;
            end
         endcase
      end
      // Pull low for acknowledge slots and zero read bits only
      nxt_r.sda_drv = (nxt_r.st == ST_ACK_DEV) || (nxt_r.st == ST_ACK_ADDR) ||
         (nxt_r.st == ST_ACK_WDATA) || (nxt_r.st == ST_RDATA && !nxt_r.shreg[7]); // [R8]
      // Wishbone slave, one wait state, unmapped reads zero
      nxt_r.wb_ack = wb_req;
      if (wb_req)
      begin
         nxt_r.wb_dat = '0;
         if (wb_adr_i == CTRL_OFS)
         begin
            nxt_r.wb_dat[CTRL_WP_BIT] = r_ff.soft_wp;
            if (wb_we_i && wb_sel_i[0])
            begin
               nxt_r.soft_wp = wb_dat_i[CTRL_WP_BIT];
            end
         end
         else if (wb_adr_i == STAT_OFS)
         begin
            nxt_r.wb_dat[STAT_BUSY_BIT] = (r_ff.busy != '0);
            nxt_r.wb_dat[STAT_STBY_BIT] = (r_ff.st == ST_IDLE) && (r_ff.busy == '0);
            nxt_r.wb_dat[STAT_WP_BIT] = wp_eff;
            nxt_r.wb_dat[STAT_PTR_LSB +: 8] = r_ff.ptr;
         end
      end
   end

   // State register; reset holds everything quiet
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         r_ff <= '0; // [R5] [R6]
         r_ff.st <= ST_IDLE;
         // Idle bus levels, so no false edge follows reset
         r_ff.scl_sy <= '1;
         r_ff.sda_sy <= '1;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   // Page buffer capture and masked array commit at cycle end
   always_ff @(posedge core_clk)
   begin
      if (buf_we)
      begin
         pbuf[buf_idx] <= r_ff.shreg;
      end
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
         if (prog_done && r_ff.mask[i])
         begin
            mem[{r_ff.page, PAGE_IDX_W'(i)}] <= pbuf[i]; // [R1] [R2]
         end
      end
   end

   assign sda_out = 1'b0; // [R8]
   assign sda_oe = r_ff.sda_drv;
   assign wb_ack_o = r_ff.wb_ack;
   assign wb_dat_o = r_ff.wb_dat;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_prog_stop;
      stop_det && r_ff.mask != '0 && r_ff.busy == '0;
   endsequence

   sequence s_devsel_done;
      r_ff.st == ST_DEVSEL && scl_fall && r_ff.cnt == BIT_FULL;
   endsequence

   a_stop_standby: assert property (stop_det |=> r_ff.st == ST_IDLE) // [R7]
      else $error("stop did not return to standby");
   a_prog_starts: assert property (s_prog_stop ##0 !wp_eff |=> r_ff.busy == BUSY_W'(PROG_CYCLES)) // [R3]
      else $error("programming cycle not started with full length");
   a_wp_blocks: assert property (s_prog_stop ##0 wp_eff |=> r_ff.busy == '0 && r_ff.mask == '0) // [R11]
      else $error("programming started under write protect");
   a_busy_silent: assert property (s_devsel_done ##0 r_ff.busy != '0 |=> r_ff.st == ST_IGNORE) // [R17]
      else $error("acknowledged while programming");
   a_addr_match: assert property (s_devsel_done ##0 !addr_hit |=> !sda_oe) // [R9]
      else $error("answered a foreign address");
   a_read_dir: assert property (r_ff.st == ST_ACK_DEV && scl_fall && r_ff.shreg[0]
      |=> r_ff.st == ST_RDATA && r_ff.ptr == $past(r_ff.ptr) + 8'h01) // [R15]
      else $error("read direction not taken");
   a_page_wrap: assert property (r_ff.st == ST_WDATA && scl_fall && r_ff.cnt == BIT_FULL
      |=> r_ff.ptr[7:4] == $past(r_ff.ptr[7:4]) && r_ff.mask[$past(r_ff.ptr[3:0])]) // [R16]
      else $error("page pointer left its page");
   a_ptr_load: assert property (r_ff.st == ST_ADDR && scl_fall && r_ff.cnt == BIT_FULL
      |=> r_ff.ptr == $past(r_ff.shreg) && r_ff.mask == '0) // [R20]
      else $error("location pointer not loaded");
   a_drive_slots: assert property (sda_oe |-> r_ff.st inside {ST_ACK_DEV, ST_ACK_ADDR,
      ST_ACK_WDATA, ST_RDATA}) // [R8]
      else $error("data line driven outside a slot");
   a_prog_end: assert property (prog_done |=> r_ff.busy == '0 && r_ff.mask == '0) // [R3]
      else $error("programming cycle did not end cleanly");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sda_oe && r_ff.busy == '0) // [R5]
      else $error("activity during reset");

endmodule : eepslv_top

// >>> verification/eepslv_mst_model.sv
`timescale 1ns/100ps
// Two-wire bus master: drives the serial clock and pulls data low
module eepslv_mst_model
#(
   parameter int HALF = 20 // Core clocks per step; clock high one step, low two, 1 MHz at most
)
(
   input wire logic core_clk, // Core clock
   input wire logic sda_oe, // Device pull-low enable
   output logic scl, // Serial clock
   output logic sda // Resolved data line
);
   logic drv_low = 1'b0;
   initial scl = 1'b1;
   // Pull-up wins unless a party pulls low
   assign sda = !(drv_low || sda_oe);
   // Wait whole core clocks
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask : hold
   // Start or repeated start, ends with clock low
   task automatic start();
      drv_low <= 1'b0;
      hold(HALF);
      scl <= 1'b1;
      hold(HALF);
      drv_low <= 1'b1;
      hold(HALF);
      scl <= 1'b0;
      hold(HALF);
   endtask : start
   // Stop: data rises while clock high
   task automatic stop();
      drv_low <= 1'b1;
      hold(HALF);
      scl <= 1'b1;
      hold(HALF);
      drv_low <= 1'b0;
      hold(HALF);
   endtask : stop
   // Eight bits plus acknowledge, MSB first, sampled at clock high
   task automatic bit9(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--)
      begin
         drv_low <= !w[i];
         hold(HALF);
         scl <= 1'b1;
         hold(HALF);
         r[i] = sda;
         scl <= 1'b0;
         hold(HALF);
      end
   endtask : bit9
endmodule : eepslv_mst_model

// >>> verification/i2c_eeprom_slave_2kbit_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("mismatch %s expected %0h seen %0h", nm, e, g); \
      end \
   end
// Self-checking bench of the two-wire memory slave
module i2c_eeprom_slave_2kbit_test import eepslv_pkg::*;;
   localparam int PROG = 2000;
   localparam logic [2:0] STRAP = 3'h5;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sda, sda_oe, sda_out, wb_ack;
   logic [2:0] strap = STRAP;
   logic wp = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_q;
   int errors = 0;
   int cmp_count = 0;
   always #12.5 core_clk = !core_clk;
   eepslv_top #(.PROG_CYCLES(PROG)) DUT (
      .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .strap_addr_bit0(strap[0]),
      .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]), .wp_in(wp),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
   eepslv_mst_model mst (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   function automatic logic [7:0] dsel(input logic rw, input logic [2:0] s);
      return {DEV_ID, s, rw};
   endfunction : dsel
   // Classic Wishbone single cycle; read data left in wb_q
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 50);
      `CHK("wb_ack", 1'b1, wb_ack)
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge core_clk);
   endtask : wb
   task automatic tx(input logic [7:0] b, input logic ak);
      logic [8:0] r;
      mst.bit9({b, 1'b1}, r);
      `CHK("ack", ak, r[0])
   endtask : tx
   task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
      mst.start();
      tx(dsel(1'b0, STRAP), 1'b0);
      tx(a, 1'b0);
      foreach (d[i]) tx(d[i], 1'b0);
      mst.stop();
   endtask : wr
   // Random then sequential read, master acks all but the last byte
   task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
      logic [8:0] r;
      mst.start();
      tx(dsel(1'b0, STRAP), 1'b0);
      tx(a, 1'b0);
      mst.start();
      tx(dsel(1'b1, STRAP), 1'b0);
      foreach (e[i])
      begin
         mst.bit9({8'hff, i == e.size() - 1}, r);
         `CHK("rdata", e[i], r[8:1])
      end
      mst.stop();
   endtask : rd
   task automatic s_por();
      rst <= 1'b1;
      mst.start();
      tx(dsel(1'b0, STRAP), 1'b1);
      mst.stop();
      rst <= 1'b0;
      mst.hold(4);
      `CHK("sda_out", 1'b0, sda_out)
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("busy", 1'b0, wb_q[STAT_BUSY_BIT])
      `CHK("standby", 1'b1, wb_q[STAT_STBY_BIT])
   endtask : s_por
   task automatic s_addr();
      mst.start();
      tx(dsel(1'b0, 3'h4), 1'b1);
      mst.start();
      tx({~DEV_ID, STRAP, 1'b0}, 1'b1);
      mst.stop();
      strap <= 3'h0;
      mst.start();
      tx(dsel(1'b0, 3'h0), 1'b0);
      mst.stop();
      strap <= STRAP;
   endtask : s_addr
   task automatic s_write();
      wr(8'h35, '{8'ha5});
      mst.start();
      tx(dsel(1'b0, STRAP), 1'b1);
      mst.stop();
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("busy", 1'b1, wb_q[STAT_BUSY_BIT])
      `CHK("standby", 1'b0, wb_q[STAT_STBY_BIT])
      mst.hold(PROG);
      mst.start();
      tx(dsel(1'b0, STRAP), 1'b0);
      mst.stop();
      rd(8'h35, '{8'ha5});
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("standby", 1'b1, wb_q[STAT_STBY_BIT])
      `CHK("pointer", 8'h36, wb_q[15:8])
   endtask : s_write
   // Eighteen bytes wrap inside one page, then a two-byte partial write
   task automatic s_page();
      logic [7:0] d[$];
      logic [7:0] e[$];
      for (int i = 0; i < 18; i++)
      begin
         d.push_back(8'h10 + 8'(i));
      end
      e = d[2:17];
      e[4] = 8'hc4;
      e[5] = 8'hc5;
      wr(8'h4e, d);
      mst.hold(PROG);
      wr(8'h44, '{8'hc4, 8'hc5});
      mst.hold(PROG);
      rd(8'h40, e);
   endtask : s_page
   task automatic s_wp();
      wp <= 1'b1;
      mst.hold(4);
      wr(8'h35, '{8'h5a});
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("busy", 1'b0, wb_q[STAT_BUSY_BIT])
      `CHK("wp", 1'b1, wb_q[STAT_WP_BIT])
      rd(8'h35, '{8'ha5});
      wp <= 1'b0;
      wb(1'b1, CTRL_OFS, 32'h1);
      wb(1'b0, CTRL_OFS, 32'h0);
      `CHK("ctrl", 32'h1, wb_q)
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("soft_wp", 1'b1, wb_q[STAT_WP_BIT])
      wr(8'h35, '{8'h3c});
      rd(8'h35, '{8'ha5});
      wb(1'b1, CTRL_OFS, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      `CHK("unmapped", 32'h0, wb_q)
   endtask : s_wp
   task automatic summarize();
      $display("checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   // Watchdog against a hung transfer
   initial
   begin
      repeat (80000) @(posedge core_clk);
      errors++;
      summarize();
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      s_por();
      s_addr();
      s_write();
      s_page();
      s_wp();
      summarize();
   end
endmodule : i2c_eeprom_slave_2kbit_test
